// File: hw/ulsf_pkg.sv
// Behaviour
// - Status bit 7 is high while any held receive character carries an error tag.
// - The receive error flag clears by itself once no remaining character is tagged.
// - Non-FIFO: bit 6 high only when holding and shift registers are both empty.
// - FIFO: bit 6 high only when transmit FIFO and shift register are empty.
// - Non-FIFO: bit 5 sets when the held character moves into the shift register.
// - Bit 5 clears at the same edge the host writes a transmit character.
// - Transmit-empty interrupt request is high while bit 5 and its enable are set.
// - FIFO: bit 5 sets when the FIFO empties, clears on any byte written.
// - Bit 4 sets when receive input stays low for a whole character frame.
// - One break character is queued per break, however long the line stays low.
// - Bit 3 reports a pending framing error and is zero after reset.
// - Framing error means missing stop bit; in FIFO mode it follows the head character.
package ulsf_pkg;
    localparam int unsigned ULSF_AW = 5;
    localparam logic [4:0] ULSF_OFS_TXDATA = 5'h00;
    localparam logic [4:0] ULSF_OFS_STATUS = 5'h04;
    localparam logic [4:0] ULSF_OFS_CTRL = 5'h08;
    localparam logic [4:0] ULSF_OFS_DIV = 5'h0c;
    localparam logic [4:0] ULSF_OFS_IRQ_STAT = 5'h10;
    localparam logic [4:0] ULSF_OFS_IRQ_MASK = 5'h14;
    localparam int unsigned ULSF_DEPTH = 16;
    localparam int unsigned ULSF_PW = 4;
    localparam logic [4:0] ULSF_CNT_FULL = 5'h10;
    localparam logic [4:0] ULSF_CNT_ONE = 5'h01;
    localparam logic [4:0] ULSF_CNT_ZERO = 5'h00;
    localparam int unsigned ULSF_STB_FERR = 7;
    localparam int unsigned ULSF_STB_TEMT = 6;
    localparam int unsigned ULSF_STB_THRE = 5;
    localparam int unsigned ULSF_STB_BRK = 4;
    localparam int unsigned ULSF_STB_FE = 3;
    localparam int unsigned ULSF_CTL_FIFO = 0;
    localparam int unsigned ULSF_CTL_THRIE = 1;
    localparam int unsigned ULSF_CTL_WLEN = 2;
    localparam int unsigned ULSF_CTL_PAR = 4;
    localparam int unsigned ULSF_CTL_STOP2 = 5;
    localparam logic [5:0] ULSF_CTL_RESET = 6'h00;
    localparam logic [15:0] ULSF_DIV_RESET = 16'h0001;
    localparam int unsigned ULSF_IRQ_THRE = 0;
    localparam int unsigned ULSF_IRQ_BRK = 1;
    localparam int unsigned ULSF_IRQ_FERR = 2;
    localparam int unsigned ULSF_IRQ_FE = 3;
    localparam int unsigned ULSF_NIRQ = 4;
    localparam logic [3:0] ULSF_MIN_DATA = 4'h5;
    localparam logic [3:0] ULSF_START_STOP = 4'h2;
    localparam int unsigned ULSF_TAG_FE = 0;
    localparam int unsigned ULSF_TAG_PE = 1;
    localparam int unsigned ULSF_TAG_BRK = 2;
    localparam int unsigned ULSF_TAGW = 3;
    typedef enum logic [1:0] {
        ULSF_BRK_IDLE = 2'b01,
        ULSF_BRK_HELD = 2'b10
    } ulsf_brk_t;
endpackage : ulsf_pkg

// File: hw/ulsf_mem.sv
`timescale 1ns/1ps
`default_nettype none
module ulsf_mem
    import ulsf_pkg::*;
#(
    parameter int unsigned W = 8
)
(
    input wire logic pclk,
    input wire logic we,
    input wire logic [ULSF_PW-1:0] waddr,
    input wire logic [W-1:0] wdata,
    input wire logic [ULSF_PW-1:0] raddr,
    output logic [W-1:0] rdata
);
    logic [W-1:0] mem [ULSF_DEPTH];

    always_ff @(posedge pclk)
    begin
        if (we)
        begin
            mem[waddr] <= wdata;
        end
    end

    // Write-first so a word written into an empty queue appears at once.
    always_ff @(posedge pclk)
    begin
        if (we && (waddr == raddr))
        begin
            rdata <= wdata;
        end
        else
        begin
            rdata <= mem[raddr];
        end
    end
endmodule : ulsf_mem
`default_nettype wire

// File: hw/ulsf_line_status.sv
`timescale 1ns/1ps
`default_nettype none
module ulsf_line_status
    import ulsf_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ULSF_AW-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic [7:0] tx_data,
    output logic tx_valid,
    input wire logic tx_taken,
    input wire logic shift_busy,
    input wire logic rx_in,
    input wire logic rx_push,
    input wire logic rx_tag_fe,
    input wire logic rx_tag_pe,
    input wire logic rx_pop,
    output logic brk_char_push,
    output logic hold_empty_irq,
    output logic irq
);
    logic acc;
    logic wr;
    logic rd;
    logic [5:0] ctrl_r;
    logic [15:0] div_r;
    logic [ULSF_NIRQ-1:0] istat_r;
    logic [ULSF_NIRQ-1:0] imask_r;
    logic [ULSF_NIRQ-1:0] iev;
    logic fifo_en;
    logic [4:0] tx_cnt_r;
    logic [4:0] tx_cnt_nxt;
    logic [4:0] tx_lim;
    logic [ULSF_PW-1:0] tx_wp_r;
    logic [ULSF_PW-1:0] tx_rp_r;
    logic [ULSF_PW-1:0] tx_rp_nxt;
    logic tx_push;
    logic tx_pop;
    logic thre_r;
    logic temt_r;
    logic [15:0] div_cnt_r;
    logic bit_tick;
    logic [3:0] frame_bits;
    logic [3:0] low_bits_r;
    ulsf_brk_t brk_st_r;
    logic brk_flag_r;
    logic brk_ev;
    logic [4:0] rx_cnt_r;
    logic [ULSF_PW-1:0] rx_wp_r;
    logic [ULSF_PW-1:0] rx_rp_r;
    logic [ULSF_PW-1:0] rx_rp_nxt;
    logic rq_push;
    logic rq_pop;
    logic [ULSF_TAGW-1:0] rq_tag;
    logic [ULSF_TAGW-1:0] head_tag;
    logic [4:0] err_cnt_r;
    logic ferr;
    logic ferr_d_r;
    logic fe_now;
    logic fe_d_r;
    logic [7:0] status_byte;

    assign acc = psel && penable;
    assign wr = acc && pwrite;
    assign rd = acc && !pwrite;
    assign pready = 1'b1;
    assign fifo_en = ctrl_r[ULSF_CTL_FIFO];

    always_comb
    begin
        pslverr = 1'b0;
        if (paddr == ULSF_OFS_TXDATA)
        begin
            pslverr = 1'b0;
        end
        else if (paddr == ULSF_OFS_STATUS)
        begin
            pslverr = 1'b0;
        end
        else if (paddr == ULSF_OFS_CTRL)
        begin
            pslverr = 1'b0;
        end
        else if (paddr == ULSF_OFS_DIV)
        begin
            pslverr = 1'b0;
        end
        else if (paddr == ULSF_OFS_IRQ_STAT)
        begin
            pslverr = 1'b0;
        end
        else if (paddr == ULSF_OFS_IRQ_MASK)
        begin
            pslverr = 1'b0;
        end
        else
        begin
            pslverr = psel && penable;
        end
    end

    // Writes to the status offset fall through and change nothing.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ctrl_r <= ULSF_CTL_RESET;
            div_r <= ULSF_DIV_RESET;
            imask_r <= '0;
        end
        else if (wr && (paddr == ULSF_OFS_CTRL))
        begin
            ctrl_r <= pwdata[5:0];
        end
        else if (wr && (paddr == ULSF_OFS_DIV))
        begin
            div_r <= pwdata[15:0];
        end
        else if (wr && (paddr == ULSF_OFS_IRQ_MASK))
        begin
            imask_r <= pwdata[ULSF_NIRQ-1:0];
        end
    end

    assign status_byte = {ferr, temt_r, thre_r, brk_flag_r, fe_now, 3'h0};

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata <= '0;
        end
        else if (psel && !penable && !pwrite)
        begin
            if (paddr == ULSF_OFS_STATUS)
            begin
                prdata <= {24'h000000, status_byte};
            end
            else if (paddr == ULSF_OFS_CTRL)
            begin
                prdata <= {26'h0, ctrl_r};
            end
            else if (paddr == ULSF_OFS_DIV)
            begin
                prdata <= {16'h0000, div_r};
            end
            else if (paddr == ULSF_OFS_IRQ_STAT)
            begin
                prdata <= {28'h0000000, istat_r};
            end
            else if (paddr == ULSF_OFS_IRQ_MASK)
            begin
                prdata <= {28'h0000000, imask_r};
            end
            else
            begin
                prdata <= '0;
            end
        end
    end

    // Transmit queue; without FIFO mode it is a single holding register.
    assign tx_lim = fifo_en ? ULSF_CNT_FULL : ULSF_CNT_ONE;
    assign tx_push = wr && (paddr == ULSF_OFS_TXDATA) && (tx_cnt_r < tx_lim);
    assign tx_pop = tx_taken && (tx_cnt_r != ULSF_CNT_ZERO);
    assign tx_valid = (tx_cnt_r != ULSF_CNT_ZERO);
    assign tx_rp_nxt = tx_pop ? tx_rp_r + 1'b1 : tx_rp_r;

    always_comb
    begin
        tx_cnt_nxt = tx_cnt_r;
        if (tx_push && !tx_pop)
        begin
            tx_cnt_nxt = tx_cnt_r + 1'b1;
        end
        else if (tx_pop && !tx_push)
        begin
            tx_cnt_nxt = tx_cnt_r - 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            tx_cnt_r <= ULSF_CNT_ZERO;
            tx_wp_r <= '0;
            tx_rp_r <= '0;
        end
        else
        begin
            tx_cnt_r <= tx_cnt_nxt;
            tx_rp_r <= tx_rp_nxt;
            if (tx_push)
            begin
                tx_wp_r <= tx_wp_r + 1'b1;
            end
        end
    end

    ulsf_mem #(.W(8)) u_tx_mem (
        .pclk(pclk),
        .we(tx_push),
        .waddr(tx_wp_r),
        .wdata(pwdata[7:0]),
        .raddr(tx_rp_nxt),
        .rdata(tx_data)
    );

    // Holding-empty follows the queue: set as it empties, cleared by a write.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            thre_r <= 1'b1;
            temt_r <= 1'b1;
        end
        else
        begin
            thre_r <= (tx_cnt_nxt == ULSF_CNT_ZERO);
            temt_r <= (tx_cnt_nxt == ULSF_CNT_ZERO) && !shift_busy && !tx_pop;
        end
    end

    assign hold_empty_irq = thre_r && ctrl_r[ULSF_CTL_THRIE];

    // Bit-time enable from the divisor.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            div_cnt_r <= '0;
        end
        else if (bit_tick)
        begin
            div_cnt_r <= '0;
        end
        else
        begin
            div_cnt_r <= div_cnt_r + 1'b1;
        end
    end

    assign bit_tick = (div_cnt_r + 1'b1 >= div_r);
    assign frame_bits = ULSF_START_STOP + ULSF_MIN_DATA + {2'b00, ctrl_r[ULSF_CTL_WLEN +: 2]}
        + {3'b000, ctrl_r[ULSF_CTL_PAR]} + {3'b000, ctrl_r[ULSF_CTL_STOP2]};

    // Break: a whole frame of low bits queues one break character per low spell.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            low_bits_r <= '0;
            brk_st_r <= ULSF_BRK_IDLE;
        end
        else
        begin
            case (brk_st_r)
                ULSF_BRK_IDLE:
                begin
                    if (rx_in)
                    begin
                        low_bits_r <= '0;
                    end
                    else if (bit_tick)
                    begin
                        low_bits_r <= low_bits_r + 1'b1;
                        if (low_bits_r + 1'b1 == frame_bits)
                        begin
                            brk_st_r <= ULSF_BRK_HELD;
                        end
                    end
                end
                ULSF_BRK_HELD:
                begin
                    low_bits_r <= '0;
                    if (rx_in)
                    begin
                        brk_st_r <= ULSF_BRK_IDLE;
                    end
                end
                default:
                begin
                    brk_st_r <= ULSF_BRK_IDLE;
                end
            endcase
        end
    end

    assign brk_ev = (brk_st_r == ULSF_BRK_IDLE) && !rx_in && bit_tick
        && (low_bits_r + 1'b1 == frame_bits);
    assign brk_char_push = brk_ev;

    // Break flag holds until the status byte is read; a new break wins.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            brk_flag_r <= 1'b0;
        end
        else if (brk_ev)
        begin
            brk_flag_r <= 1'b1;
        end
        else if (rd && (paddr == ULSF_OFS_STATUS))
        begin
            brk_flag_r <= 1'b0;
        end
    end

    // Receive error tags travel with the characters in the receive queue.
    assign rq_push = (rx_push || brk_ev) && (rx_cnt_r != ULSF_CNT_FULL);
    assign rq_pop = rx_pop && (rx_cnt_r != ULSF_CNT_ZERO);
    assign rq_tag = {brk_ev, rx_push && rx_tag_pe, rx_push && rx_tag_fe};
    assign rx_rp_nxt = rq_pop ? rx_rp_r + 1'b1 : rx_rp_r;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            rx_cnt_r <= ULSF_CNT_ZERO;
            rx_wp_r <= '0;
            rx_rp_r <= '0;
            err_cnt_r <= ULSF_CNT_ZERO;
        end
        else
        begin
            rx_rp_r <= rx_rp_nxt;
            if (rq_push)
            begin
                rx_wp_r <= rx_wp_r + 1'b1;
            end
            if (rq_push && !rq_pop)
            begin
                rx_cnt_r <= rx_cnt_r + 1'b1;
            end
            else if (rq_pop && !rq_push)
            begin
                rx_cnt_r <= rx_cnt_r - 1'b1;
            end
            if ((rq_push && (rq_tag != '0)) && !(rq_pop && (head_tag != '0)))
            begin
                err_cnt_r <= err_cnt_r + 1'b1;
            end
            else if (!(rq_push && (rq_tag != '0)) && (rq_pop && (head_tag != '0)))
            begin
                err_cnt_r <= err_cnt_r - 1'b1;
            end
        end
    end

    ulsf_mem #(.W(ULSF_TAGW)) u_rx_tags (
        .pclk(pclk),
        .we(rq_push),
        .waddr(rx_wp_r),
        .wdata(rq_tag),
        .raddr(rx_rp_nxt),
        .rdata(head_tag)
    );

    assign ferr = (err_cnt_r != ULSF_CNT_ZERO);
    assign fe_now = (rx_cnt_r != ULSF_CNT_ZERO) && head_tag[ULSF_TAG_FE];

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ferr_d_r <= 1'b0;
            fe_d_r <= 1'b0;
        end
        else
        begin
            ferr_d_r <= ferr;
            fe_d_r <= fe_now;
        end
    end

    assign iev = {fe_now && !fe_d_r, ferr && !ferr_d_r, brk_ev, tx_pop && (tx_cnt_r == ULSF_CNT_ONE)
        && !tx_push};

    // Sticky event bits, cleared by writing one; a new event wins over the clear.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            istat_r <= '0;
        end
        else if (wr && (paddr == ULSF_OFS_IRQ_STAT))
        begin
            istat_r <= (istat_r & ~pwdata[ULSF_NIRQ-1:0]) | iev;
        end
        else
        begin
            istat_r <= istat_r | iev;
        end
    end

    assign irq = |(istat_r & imask_r);
endmodule : ulsf_line_status
`default_nettype wire

// File: tb/ulsf_line_status_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module ulsf_line_status_asserts
    import ulsf_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ULSF_AW-1:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic tx_valid,
    input wire logic tx_taken,
    input wire logic shift_busy,
    input wire logic rx_in,
    input wire logic brk_char_push,
    input wire logic hold_empty_irq
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    logic rd_st;
    logic tx_wr;
    assign rd_st = psel && penable && !pwrite && paddr == ULSF_OFS_STATUS;
    assign tx_wr = psel && penable && pwrite && paddr == ULSF_OFS_TXDATA;
    sequence held_s(x);
        x ##1 x ##1 x;
    endsequence
    queue_wait_a: assert property (
        held_s(tx_valid) ##1 rd_st |-> prdata[6:5] == 2'h0)
        else $error("empty flags shown while a character waits");
    shift_busy_a: assert property (
        held_s(shift_busy) ##1 rd_st |-> !prdata[6])
        else $error("transmitter empty shown while shifting");
    thre_clear_a: assert property (tx_wr && !tx_taken |=> !hold_empty_irq)
        else $error("holding empty request after a write");
    irq_empty_a: assert property (hold_empty_irq |-> !tx_valid || $rose(tx_valid))
        else $error("holding empty request with a queued character");
    load_pop_a: assert property ($fell(tx_valid) |-> $past(tx_taken))
        else $error("queue emptied without a shift load");
    write_push_a: assert property ($rose(tx_valid) |-> $past(tx_wr))
        else $error("queue filled without a write");
    break_low_a: assert property (brk_char_push |-> !rx_in && !$past(rx_in))
        else $error("break reported with the line high");
    break_once_a: assert property (brk_char_push |=> !brk_char_push until rx_in)
        else $error("second break character in one break");
endmodule : ulsf_line_status_asserts
bind ulsf_line_status ulsf_line_status_asserts ulsf_line_status_asserts_inst (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .prdata, .tx_valid, .tx_taken,
    .shift_busy, .rx_in, .brk_char_push, .hold_empty_irq
);
`default_nettype wire

// File: tb/ulsf_tsr_model.sv
`timescale 1ns/1ps
`default_nettype none
module ulsf_shift_model (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic hold,
    input wire logic [7:0] tx_data,
    input wire logic tx_valid,
    output logic tx_taken,
    output logic shift_busy,
    output logic [7:0] last_byte,
    output logic [7:0] n_taken
);
    logic [3:0] left_r;
    assign tx_taken = tx_valid && !hold && left_r == 4'h0;
    assign shift_busy = left_r != 4'h0;
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            left_r <= 4'h0;
            last_byte <= 8'h00;
            n_taken <= 8'h00;
        end
        else if (tx_taken)
        begin
            left_r <= 4'h9;
            last_byte <= tx_data;
            n_taken <= n_taken + 8'h01;
        end
        else if (shift_busy)
            left_r <= left_r - 4'h1;
    end
endmodule : ulsf_shift_model
`default_nettype wire

// File: tb/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top
    import ulsf_pkg::*;
;
    typedef struct {
        logic [4:0] a;
        logic [31:0] d;
        logic [31:0] q;
        logic e;
    } ulsf_row_t;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel, penable, pwrite, hold, rx_in, rx_push, rx_tag_fe, rx_tag_pe, rx_pop, err;
    logic [4:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic pready, pslverr, tx_valid, tx_taken, shift_busy, brk_char_push, hold_empty_irq, irq;
    logic [7:0] tx_data, last_byte, n_taken;
    int brk_n, bad_count, num_checks;
    ulsf_row_t rows [5] = '{
        '{ULSF_OFS_CTRL, 32'h3d, 32'h3d, 1'b0},
        '{ULSF_OFS_DIV, 32'h3, 32'h3, 1'b0},
        '{ULSF_OFS_IRQ_MASK, 32'hf, 32'hf, 1'b0},
        '{ULSF_OFS_STATUS, 32'hff, 32'h60, 1'b0},
        '{5'h18, 32'h1, 32'h0, 1'b1}
    };
    logic [31:0] rx_exp [4] = '{32'he8, 32'he0, 32'he0, 32'h60};
    always #25 pclk = ~pclk;
    always @(posedge pclk)
    begin
        if (brk_char_push === 1'b1)
            brk_n <= brk_n + 1;
    end
    ulsf_line_status ulsf_line_status_inst (
        .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr, .tx_data, .tx_valid, .tx_taken, .shift_busy, .rx_in, .rx_push, .rx_tag_fe,
        .rx_tag_pe, .rx_pop, .brk_char_push, .hold_empty_irq, .irq
    );
    ulsf_shift_model ulsf_shift_model_inst (
        .pclk, .presetn, .hold, .tx_data, .tx_valid, .tx_taken, .shift_busy, .last_byte,
        .n_taken
    );
    task automatic final_report();
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : final_report
    task automatic timeout();
        bad_count++;
        final_report();
    endtask : timeout
    task automatic chk(input string s, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("unexpected %s: expected %h seen %h", s, exp, seen);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [4:0] a, input logic [31:0] d);
        int n;
        @(posedge pclk);
        {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (pready !== 1'b1 && n < 9);
        if (pready !== 1'b1)
            timeout();
        {rd, err} = {prdata, pslverr};
        {psel, penable} <= 2'h0;
    endtask : apb
    task automatic wait_v(input logic sel_irq, input logic v);
        int n;
        for (n = 0; (sel_irq ? hold_empty_irq : shift_busy) !== v; n++)
        begin
            if (n == 500)
                timeout();
            @(posedge pclk);
        end
    endtask : wait_v
    task automatic rxev(input logic [3:0] v);
        @(posedge pclk);
        {rx_push, rx_tag_fe, rx_tag_pe, rx_pop} <= v;
        @(posedge pclk);
        {rx_push, rx_tag_fe, rx_tag_pe, rx_pop} <= 4'h0;
    endtask : rxev
    task automatic st(input int p);
        repeat (p) @(posedge pclk);
        apb(1'b0, ULSF_OFS_STATUS, 32'h0);
    endtask : st
    initial
    begin
        {psel, penable, pwrite, hold, rx_push, rx_tag_fe, rx_tag_pe, rx_pop} = 8'h0;
        rx_in = 1'b1;
        paddr = 5'h0;
        pwdata = 32'h0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        st(0);
        chk("status reset", rd, 32'h60);
        chk("outputs reset", {hold_empty_irq, irq, tx_valid}, 3'h0);
        foreach (rows[i])
        begin
            apb(1'b1, rows[i].a, rows[i].d);
            apb(1'b0, rows[i].a, 32'h0);
            chk("readback", rd, rows[i].q);
            chk("slverr", err, rows[i].e);
        end
        hold <= 1'b1;
        apb(1'b1, ULSF_OFS_CTRL, 32'h2);
        apb(1'b1, ULSF_OFS_TXDATA, 32'ha5);
        apb(1'b1, ULSF_OFS_TXDATA, 32'h5a);
        st(0);
        chk("status held", rd, 32'h0);
        chk("held head", {hold_empty_irq, tx_data}, 9'h0a5);
        hold <= 1'b0;
        wait_v(1'b0, 1'b1);
        st(2);
        chk("status shifting", rd, 32'h20);
        chk("empty request", hold_empty_irq, 1'b1);
        wait_v(1'b0, 1'b0);
        st(3);
        chk("status idle", rd, 32'h60);
        chk("bytes sent", {n_taken, last_byte}, 16'h01a5);
        apb(1'b0, ULSF_OFS_IRQ_STAT, 32'h0);
        chk("irq status", rd, 32'h1);
        chk("irq line", irq, 1'b1);
        apb(1'b1, ULSF_OFS_IRQ_MASK, 32'h0);
        @(posedge pclk);
        chk("irq masked", irq, 1'b0);
        apb(1'b1, ULSF_OFS_IRQ_MASK, 32'hf);
        apb(1'b1, ULSF_OFS_IRQ_STAT, 32'hf);
        @(posedge pclk);
        chk("irq cleared", irq, 1'b0);
        hold <= 1'b1;
        apb(1'b1, ULSF_OFS_CTRL, 32'h3);
        for (int i = 0; i < 17; i++)
            apb(1'b1, ULSF_OFS_TXDATA, 32'(i));
        st(0);
        chk("status queued", rd, 32'h0);
        hold <= 1'b0;
        wait_v(1'b1, 1'b1);
        wait_v(1'b0, 1'b0);
        st(3);
        chk("status drained", rd, 32'h60);
        chk("queue drained", {n_taken, last_byte}, 16'h110f);
        apb(1'b1, ULSF_OFS_IRQ_STAT, 32'hf);
        rxev(4'hc);
        rxev(4'h8);
        rxev(4'ha);
        for (int i = 0; i < 4; i++)
        begin
            if (i > 0)
                rxev(4'h1);
            st(2);
            chk("rx status", rd, rx_exp[i]);
        end
        apb(1'b0, ULSF_OFS_IRQ_STAT, 32'h0);
        chk("rx irq", rd, 32'hc);
        chk("rx irq line", irq, 1'b1);
        apb(1'b1, ULSF_OFS_CTRL, 32'h3d);
        apb(1'b1, ULSF_OFS_IRQ_STAT, 32'hf);
        rx_in <= 1'b0;
        repeat (30) @(posedge pclk);
        chk("early break", brk_n, 0);
        repeat (100) @(posedge pclk);
        chk("break count", brk_n, 1);
        st(0);
        chk("break status", {rd[7], rd[4]}, 2'h3);
        st(0);
        chk("break read", {brk_n[1:0], rd[4]}, 3'h2);
        rx_in <= 1'b1;
        rxev(4'h1);
        st(2);
        chk("break popped", rd[7], 1'b0);
        hold <= 1'b1;
        apb(1'b1, ULSF_OFS_TXDATA, 32'h11);
        @(posedge pclk);
        chk("queue before reset", tx_valid, 1'b1);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        chk("queue reset", tx_valid, 1'b0);
        presetn <= 1'b1;
        st(0);
        chk("status rerun", rd, 32'h60);
        apb(1'b0, ULSF_OFS_CTRL, 32'h0);
        chk("ctrl rerun", rd, 32'h0);
        final_report();
    end
endmodule : tb_top
`default_nettype wire
